/* verilog/hred_decode.sv */
`timescale 1ns/1ns
module hred_decode
    import hred_pkg::*;
#(
    parameter logic [DATA_W-1:0] CHIP_ID_VALUE = 8'h5A, // arbitrary value
    parameter logic [DATA_W-1:0] CHIP_VERSION_VALUE = 8'h01 // arbitrary value
) (
    // clock and hardware reset pin
    input wire logic clock,
    input wire logic reset,
    // host cycle and answer
    input wire hred_req_s host_req,
    output logic [DATA_W-1:0] host_rdata,
    output logic host_rdata_valid,
    output logic local_bus_claim_n,
    output logic bus_cycle_ready_n,
    // configuration from the rest of the chip
    input wire logic color_emulation,
    input wire logic bus_is_pci,
    input wire logic [1:0] pci_cmd_enable,
    // board straps, sampled after reset release
    input wire logic [3:0] strap_port_base_digit,
    input wire logic strap_onboard,
    // cycles passed on to the register groups and memory
    output hred_fwd_s fwd,
    input wire logic [DATA_W-1:0] fwd_rdata,
    // status
    output logic host_access_enabled,
    output logic [3:0] port_base_digit_field
);

    // straps come from pins: two stages before use
    logic [4:0] strap_meta_q;
    logic [4:0] strap_sync_q;
    logic strap_done_q;
    logic [3:0] base_digit_q;
    logic onboard_cfg_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            strap_meta_q <= '0;
            strap_sync_q <= '0;
        end else begin
            strap_meta_q <= {strap_onboard, strap_port_base_digit};
            strap_sync_q <= strap_meta_q;
        end
    end

    // capture once, on the third edge after the release so the sync chain is settled
    logic [1:0] strap_wait_q;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            strap_wait_q <= '0;
            strap_done_q <= 1'b0;
            base_digit_q <= PORT_BASE_DIGIT_RESET;
            onboard_cfg_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_wait_q <= strap_wait_q + 2'h1;
            if (strap_wait_q == STRAP_SETTLE_CNT) begin
                strap_done_q <= 1'b1;
                base_digit_q <= strap_sync_q[3:0];
                onboard_cfg_q <= strap_sync_q[4];
            end
        end
    end

    // request kinds
    wire is_io = host_req.valid && host_req.kind == HRED_KIND_IO;
    wire is_mem = host_req.valid && host_req.kind == HRED_KIND_MEM;
    wire is_cfg = host_req.valid && host_req.kind == HRED_KIND_CFG;
    wire [15:0] io_addr = host_req.addr[IO_ADDR_W-1:0];
    wire [7:0] low_off = host_req.addr[7:0];

    // enable registers: only the reset pin presets them
    logic addon_en_q;
    logic onboard_en_q;
    wire hit_onboard = is_io && io_addr == PORT_ONBOARD_EN;
    wire hit_addon = is_io && io_addr == PORT_ADDON_EN;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            addon_en_q <= ADDON_EN_RESET;
            onboard_en_q <= ONBOARD_EN_RESET;
        end else begin
            if (hit_addon && host_req.write) begin
                addon_en_q <= host_req.wdata[ADDON_EN_BIT];
            end
            if (hit_onboard && host_req.write) begin
                onboard_en_q <= host_req.wdata[ONBOARD_EN_BIT];
            end
        end
    end

    // strapped board style picks which enable register counts
    wire legacy_en = onboard_cfg_q ? onboard_en_q : addon_en_q;
    wire io_ok = bus_is_pci ? pci_cmd_enable[PCI_IO_EN_BIT] : legacy_en;
    wire mem_ok = bus_is_pci ? pci_cmd_enable[PCI_MEM_EN_BIT] : legacy_en;
    assign host_access_enabled = io_ok || mem_ok;
    assign port_base_digit_field = base_digit_q;

    // fixed and variable port decode; nothing else matches, so the
    // legacy setup ports fall through unclaimed
    wire [11:0] var_hi = color_emulation ? PORT_VAR_COLOR : PORT_VAR_MONO;
    wire in_var = io_addr[15:4] == var_hi;
    wire is_ext_pair = io_addr[15:1] == PORT_EXT_INDEX[15:1];
    wire lo_crt = io_addr[3:0] == PORT_CRT_INDEX_LO || io_addr[3:0] == PORT_CRT_DATA_LO;
    wire io_go = is_io && io_ok;
    wire hit_crt = io_go && in_var && lo_crt;
    wire hit_var = io_go && in_var && !lo_crt && !is_ext_pair;
    wire hit_seq = io_go && io_addr[15:1] == PORT_SEQ_PAIR[15:1];
    wire hit_gfx = io_go && io_addr[15:1] == PORT_GFX_PAIR[15:1];
    wire hit_attr = io_go && io_addr[15:1] == PORT_ATTR_PAIR[15:1];
    wire hit_eidx = io_go && io_addr == PORT_EXT_INDEX;
    wire hit_edat = io_go && io_addr == PORT_EXT_DATA;

    // system registers: io window off pci, config cycles on pci
    wire sys_io = io_go && !bus_is_pci && io_addr[15:12] == SYS_PORT_HI
        && io_addr[11:8] == base_digit_q && low_off <= SYS_PORT_LAST;
    wire sys_cfg = is_cfg && bus_is_pci && low_off <= SYS_PORT_LAST;
    wire hit_sys = sys_io || sys_cfg;
    wire hit_mbase = hit_sys && low_off[7:2] == SYS_MMIO_BASE_OFF[7:2];
    wire [1:0] mbase_byte = low_off[1:0];

    // extended index pointer and local extended registers
    logic [DATA_W-1:0] ext_index_q;
    always_ff @(posedge clock) begin
        if (hit_eidx && host_req.write) begin
            ext_index_q <= host_req.wdata;
        end
    end

    wire ext_is_id = ext_index_q == EXT_IDX_ID;
    wire ext_is_ver = ext_index_q == EXT_IDX_VERSION;
    wire ext_is_scr = ext_index_q[7:SCRATCH_IW] == EXT_IDX_SCRATCH[7:SCRATCH_IW];
    wire ext_is_sys = ext_index_q >= EXT_IDX_SYS_FIRST && ext_index_q <= EXT_IDX_SYS_LAST;
    wire ext_local = ext_is_id || ext_is_ver || ext_is_scr;
    wire [SCRATCH_IW-1:0] scr_sel = ext_index_q[SCRATCH_IW-1:0];

    // scratch has no default: left alone by reset
    logic [DATA_W-1:0] scratch_q [SCRATCH_N];
    for (genvar i = 0; i < SCRATCH_N; i++) begin : g_scratch
        always_ff @(posedge clock) begin
            if (hit_edat && host_req.write && ext_is_scr
                    && scr_sel == SCRATCH_IW'(i)) begin
                scratch_q[i] <= host_req.wdata;
            end
        end
    end

    // mmio base: low byte is below the window size and reads zero
    logic [DATA_W-1:0] mbase_q [MMIO_BYTES];
    assign mbase_q[0] = '0;
    for (genvar b = 1; b < MMIO_BYTES; b++) begin : g_mbase
        always_ff @(posedge clock) begin
            if (hit_mbase && host_req.write && mbase_byte == 2'(b)) begin
                mbase_q[b] <= host_req.wdata;
            end
        end
    end
    wire [MEM_ADDR_W-1:0] mbase_word = {mbase_q[3], mbase_q[2], mbase_q[1], mbase_q[0]};

    // memory cycles: window hits go to cursor/window/engine groups only
    wire mem_go = is_mem && mem_ok;
    wire hit_mmio = mem_go && host_req.addr[MEM_ADDR_W-1:MMIO_WIN_LSB]
        == mbase_word[MEM_ADDR_W-1:MMIO_WIN_LSB];
    wire hit_vmem = mem_go && !hit_mmio;

    // enable write at the on-board port is taken but never claimed
    wire claim = (hit_addon) || hit_crt || hit_var || hit_seq || hit_gfx || hit_attr
        || hit_eidx || hit_edat || hit_sys || hit_mmio || hit_vmem;

    // where the cycle goes when it is not held here
    wire hred_grp_e grp_d =
        hit_crt ? HRED_GRP_CRT :
        hit_var ? HRED_GRP_VAR :
        hit_seq ? HRED_GRP_SEQ :
        hit_gfx ? HRED_GRP_GFX :
        hit_attr ? HRED_GRP_ATTR :
        (hit_edat && ext_is_sys) ? HRED_GRP_EXT_SYS :
        (hit_edat && !ext_local) ? HRED_GRP_EXT :
        (hit_sys && !hit_mbase) ? HRED_GRP_SYS :
        hit_mmio ? HRED_GRP_MMIO :
        hit_vmem ? HRED_GRP_VMEM :
        HRED_GRP_NONE;

    wire [MEM_ADDR_W-1:0] fwd_addr_d =
        hit_edat ? MEM_ADDR_W'(ext_index_q) :
        (hit_sys || hit_mmio) ? MEM_ADDR_W'(low_off) :
        host_req.addr;

    // local read data, reserved bits forced to zero
    wire [DATA_W-1:0] rd_addon = DATA_W'(addon_en_q) << ADDON_EN_BIT;
    wire [DATA_W-1:0] rd_ext =
        ext_is_id ? CHIP_ID_VALUE :
        ext_is_ver ? CHIP_VERSION_VALUE :
        scratch_q[scr_sel];
    wire [DATA_W-1:0] rdata_d =
        hit_addon ? rd_addon :
        hit_eidx ? ext_index_q :
        (hit_edat && ext_local) ? rd_ext :
        hit_mbase ? mbase_q[mbase_byte] :
        '0;

    // id and version ignore writes; forwarded reads take group data
    logic ack_q;
    logic rd_q;
    logic rd_fwd_q;
    logic [DATA_W-1:0] rdata_q;
    hred_fwd_s fwd_q;
    wire hred_fwd_s fwd_d = '{valid: grp_d != HRED_GRP_NONE, grp: grp_d,
        write: host_req.write, addr: fwd_addr_d, wdata: host_req.wdata};

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
            rd_q <= 1'b0;
            rd_fwd_q <= 1'b0;
            rdata_q <= '0;
            fwd_q <= '0;
        end else begin
            ack_q <= claim;
            rd_q <= claim && !host_req.write;
            rd_fwd_q <= grp_d != HRED_GRP_NONE;
            rdata_q <= rdata_d;
            fwd_q <= fwd_d;
        end
    end

    // one-cycle answer the edge after the request
    assign local_bus_claim_n = !ack_q;
    assign bus_cycle_ready_n = !ack_q;
    assign host_rdata_valid = rd_q;
    assign host_rdata = rd_fwd_q ? fwd_rdata : rdata_q;
    assign fwd = fwd_q;

endmodule

/* shared/hred_pkg.sv */
package hred_pkg;

    localparam int IO_ADDR_W = 16;
    localparam int MEM_ADDR_W = 32;
    localparam int DATA_W = 8;

    // fixed host port addresses
    localparam logic [15:0] PORT_ONBOARD_EN = 16'h03C3;
    localparam logic [15:0] PORT_ADDON_EN = 16'h46E8;
    localparam logic [15:0] PORT_EXT_INDEX = 16'h03DE;
    localparam logic [15:0] PORT_EXT_DATA = 16'h03DF;
    localparam logic [15:0] PORT_SEQ_PAIR = 16'h03C4;
    localparam logic [15:0] PORT_GFX_PAIR = 16'h03CE;
    localparam logic [15:0] PORT_ATTR_PAIR = 16'h03C0;

    // variable-nibble ranges and crt pair position inside them
    localparam logic [11:0] PORT_VAR_MONO = 12'h03B;
    localparam logic [11:0] PORT_VAR_COLOR = 12'h03D;
    localparam logic [3:0] PORT_CRT_INDEX_LO = 4'h4;
    localparam logic [3:0] PORT_CRT_DATA_LO = 4'h5;

    // enable register fields and reset values
    localparam int ADDON_EN_BIT = 3;
    localparam int ONBOARD_EN_BIT = 0;
    localparam logic ADDON_EN_RESET = 1'h0;
    localparam logic ONBOARD_EN_RESET = 1'h0;
    localparam int PCI_IO_EN_BIT = 0;
    localparam int PCI_MEM_EN_BIT = 1;

    // configuration-style system registers
    localparam logic [3:0] SYS_PORT_HI = 4'h2;
    localparam logic [7:0] SYS_PORT_LAST = 8'h3F;
    localparam logic [7:0] SYS_MMIO_BASE_OFF = 8'h10;
    localparam int MMIO_WIN_LSB = 8;
    localparam int MMIO_BYTES = 4;
    localparam logic [3:0] PORT_BASE_DIGIT_RESET = 4'h0;
    // strap capture waits until the sync chain holds post-reset pin levels
    localparam logic [1:0] STRAP_SETTLE_CNT = 2'h2;

    // extended index map
    localparam logic [7:0] EXT_IDX_ID = 8'h00;
    localparam logic [7:0] EXT_IDX_VERSION = 8'h01;
    localparam logic [7:0] EXT_IDX_SCRATCH = 8'hF0;
    localparam int SCRATCH_N = 8;
    localparam int SCRATCH_IW = 3;
    localparam logic [7:0] EXT_IDX_SYS_FIRST = 8'h10;
    localparam logic [7:0] EXT_IDX_SYS_LAST = 8'h1F;

    typedef enum logic [1:0] {
        HRED_KIND_IO,
        HRED_KIND_MEM,
        HRED_KIND_CFG
    } hred_kind_e;

    typedef enum logic [3:0] {
        HRED_GRP_NONE,
        HRED_GRP_CRT,
        HRED_GRP_VAR,
        HRED_GRP_SEQ,
        HRED_GRP_GFX,
        HRED_GRP_ATTR,
        HRED_GRP_EXT,
        HRED_GRP_EXT_SYS,
        HRED_GRP_SYS,
        HRED_GRP_MMIO,
        HRED_GRP_VMEM
    } hred_grp_e;

    typedef struct packed {
        logic valid;
        hred_kind_e kind;
        logic write;
        logic [MEM_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } hred_req_s;

    typedef struct packed {
        logic valid;
        hred_grp_e grp;
        logic write;
        logic [MEM_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } hred_fwd_s;

endpackage

/* verification/hred_decode_monitor.sv */
`timescale 1ns/1ns
module hred_decode_monitor
    import hred_pkg::*;
(
    // watched ports
    input wire logic clock,
    input wire logic reset,
    input wire hred_req_s host_req,
    input wire logic [DATA_W-1:0] host_rdata,
    input wire logic host_rdata_valid,
    input wire logic local_bus_claim_n,
    input wire logic bus_cycle_ready_n,
    input wire logic color_emulation,
    input wire logic bus_is_pci,
    input wire hred_fwd_s fwd,
    input wire logic [DATA_W-1:0] fwd_rdata,
    input wire logic host_access_enabled
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire io_rq = host_req.valid && host_req.kind == HRED_KIND_IO;
    wire [15:0] pa = host_req.addr[15:0];
    wire [15:0] crt_a = {color_emulation ? PORT_VAR_COLOR : PORT_VAR_MONO, PORT_CRT_INDEX_LO};
    wire legacy = pa == 16'h0048 || pa == 16'h0094 || pa == 16'h0102;
    wire en_isa = !bus_is_pci && host_access_enabled;
    sequence s_claimed;
        !local_bus_claim_n && !bus_cycle_ready_n;
    endsequence
    sequence s_silent;
        local_bus_claim_n && bus_cycle_ready_n && !fwd.valid;
    endsequence
    a_claim_ready_pair: assert property (local_bus_claim_n == bus_cycle_ready_n)
        else $error("claim and ready differ");
    a_claim_has_cause: assert property (!local_bus_claim_n |-> $past(host_req.valid))
        else $error("claim without request");
    a_onboard_stays_silent: assert property (io_rq && pa == PORT_ONBOARD_EN |=> s_silent)
        else $error("onboard port cycle was answered");
    a_legacy_not_decoded: assert property (io_rq && legacy |=> s_silent)
        else $error("legacy port answered");
    a_addon_read_value: assert property (io_rq && !host_req.write && pa == PORT_ADDON_EN
        |=> s_claimed ##0 host_rdata_valid && host_rdata[7:4] == 4'h0
        && host_rdata[2:0] == 3'h0)
        else $error("addon enable readback wrong");
    a_disabled_ignores: assert property (io_rq && !bus_is_pci && !host_access_enabled
        && pa == PORT_SEQ_PAIR |=> s_silent)
        else $error("cycle taken while disabled");
    a_crt_pair_fwd: assert property (io_rq && en_isa && pa[15:1] == crt_a[15:1]
        |=> s_claimed ##0 fwd.valid && fwd.grp == HRED_GRP_CRT)
        else $error("crt pair not forwarded");
    a_fwd_read_data: assert property (fwd.valid && !fwd.write
        |-> host_rdata_valid && host_rdata == fwd_rdata)
        else $error("forwarded read data lost");
endmodule
bind hred_decode hred_decode_monitor i_hred_decode_monitor(.clock(clock), .reset(reset),
    .host_req(host_req), .host_rdata(host_rdata), .host_rdata_valid(host_rdata_valid),
    .local_bus_claim_n(local_bus_claim_n), .bus_cycle_ready_n(bus_cycle_ready_n),
    .color_emulation(color_emulation), .bus_is_pci(bus_is_pci), .fwd(fwd),
    .fwd_rdata(fwd_rdata), .host_access_enabled(host_access_enabled));

/* verification/hred_group_model.sv */
`timescale 1ns/1ns
module hred_group_model
    import hred_pkg::*;
(
    // clock and forwarded cycle
    input wire logic clock,
    input wire hred_fwd_s fwd,
    output logic [DATA_W-1:0] fwd_rdata
);
    logic [DATA_W-1:0] junk_q = 8'h00;
    // idle data churns so a stale byte never passes for an answer
    always @(posedge clock) junk_q <= junk_q + 8'h35;
    assign fwd_rdata = fwd.valid ? fwd.addr[7:0] ^ 8'h3C : junk_q;
endmodule

/* verification/tb.sv */
`timescale 1ns/1ns
module tb;
    import hred_pkg::*;
    localparam hred_kind_e IO = HRED_KIND_IO;
    logic clock = 1'b0, reset = 1'b1, color_emulation = 1'b1, bus_is_pci = 1'b0;
    logic strap_onboard = 1'b0, host_rdata_valid, local_bus_claim_n, bus_cycle_ready_n;
    logic host_access_enabled;
    logic [1:0] pci_cmd_enable = 2'h0;
    logic [3:0] strap_port_base_digit = 4'h3, port_base_digit_field;
    logic [7:0] host_rdata, fwd_rdata, r;
    hred_req_s host_req = '0;
    hred_fwd_s fwd;
    int errors = 0, total_checks = 0, seed = 20;
    int scratch[8];
    logic [15:0] pt[5] = '{16'h03C4, 16'h03C5, 16'h03CF, 16'h03C0, 16'h03C1};
    hred_grp_e gp[5] = '{HRED_GRP_SEQ, HRED_GRP_SEQ, HRED_GRP_GFX, HRED_GRP_ATTR, HRED_GRP_ATTR};
    logic [15:0] lg[3] = '{16'h0048, 16'h0094, 16'h0102};
    hred_decode i_hred_decode(.clock(clock), .reset(reset), .host_req(host_req),
        .host_rdata(host_rdata), .host_rdata_valid(host_rdata_valid),
        .local_bus_claim_n(local_bus_claim_n), .bus_cycle_ready_n(bus_cycle_ready_n),
        .color_emulation(color_emulation), .bus_is_pci(bus_is_pci),
        .pci_cmd_enable(pci_cmd_enable), .strap_port_base_digit(strap_port_base_digit),
        .strap_onboard(strap_onboard), .fwd(fwd), .fwd_rdata(fwd_rdata),
        .host_access_enabled(host_access_enabled),
        .port_base_digit_field(port_base_digit_field));
    hred_group_model i_hred_group_model(.clock(clock), .fwd(fwd), .fwd_rdata(fwd_rdata));
    initial forever #5 clock = ~clock;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one host cycle, answer looked at in its only cycle
    task automatic acc(input hred_kind_e k, input logic w, input logic [31:0] a,
            input logic [7:0] wd, input logic cl, input hred_grp_e g, output logic [7:0] rd);
        @(negedge clock);
        host_req = '{1'b1, k, w, a, wd};
        @(negedge clock);
        host_req.valid = 1'b0;
        rd = host_rdata;
        chk(local_bus_claim_n, !cl);
        chk(bus_cycle_ready_n, !cl);
        chk(fwd.valid ? fwd.grp : HRED_GRP_NONE, g);
        chk(host_rdata_valid, cl && !w);
        if (g != HRED_GRP_NONE) begin
            chk(fwd.write, w);
            chk(fwd.wdata, wd);
        end
    endtask
    task automatic start();
        repeat (6) @(negedge clock);
        reset = 1'b0;
        repeat (4) @(negedge clock);
        chk(host_access_enabled, 1'b0);
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        end_of_test();
    end
    initial begin
        start();
        acc(IO, 0, PORT_ADDON_EN, 0, 1, HRED_GRP_NONE, r);
        chk(r, 8'h00);
        acc(IO, 0, PORT_SEQ_PAIR, 0, 0, HRED_GRP_NONE, r);
        acc(IO, 1, PORT_ADDON_EN, 8'hFF, 1, HRED_GRP_NONE, r);
        acc(IO, 0, PORT_ADDON_EN, 0, 1, HRED_GRP_NONE, r);
        chk(r, 8'h08);
        chk(host_access_enabled, 1'b1);
        for (int c = 0; c < 2; c++) begin
            color_emulation = c[0];
            acc(IO, 0, {c ? PORT_VAR_COLOR : PORT_VAR_MONO, PORT_CRT_DATA_LO}, 0, 1,
                HRED_GRP_CRT, r);
            chk(r, 8'({c ? PORT_VAR_COLOR : PORT_VAR_MONO, PORT_CRT_DATA_LO}) ^ 8'h3C);
            acc(IO, 0, {c ? PORT_VAR_COLOR : PORT_VAR_MONO, 4'hA}, 0, 1, HRED_GRP_VAR, r);
        end
        foreach (pt[i]) begin
            acc(IO, 1, pt[i], 8'($random(seed)), 1, gp[i], r);
            acc(IO, 0, pt[i], 0, 1, gp[i], r);
            chk(r, pt[i][7:0] ^ 8'h3C);
        end
        foreach (lg[i]) acc(IO, i[0], lg[i], 8'h5A, 0, HRED_GRP_NONE, r);
        // chipset owns the answer to this port
        acc(IO, 1, PORT_ONBOARD_EN, 8'h00, 0, HRED_GRP_NONE, r);
        acc(IO, 0, PORT_ONBOARD_EN, 0, 0, HRED_GRP_NONE, r);
        for (int i = 0; i < 2 * SCRATCH_N; i++) begin
            if (i < SCRATCH_N) scratch[i] = $random(seed);
            acc(IO, 1, PORT_EXT_INDEX, EXT_IDX_SCRATCH + i % 8, 1, HRED_GRP_NONE, r);
            acc(IO, i < 8, PORT_EXT_DATA, scratch[i % 8][7:0], 1, HRED_GRP_NONE, r);
            if (i >= 8) chk(r, scratch[i % 8][7:0]);
        end
        acc(IO, 0, PORT_EXT_INDEX, 0, 1, HRED_GRP_NONE, r);
        chk(r, EXT_IDX_SCRATCH + 8'h07);
        for (int i = 0; i < 2; i++) begin
            acc(IO, 1, PORT_EXT_INDEX, i, 1, HRED_GRP_NONE, r);
            acc(IO, 1, PORT_EXT_DATA, 8'hFF, 1, HRED_GRP_NONE, r);
            acc(IO, 0, PORT_EXT_DATA, 0, 1, HRED_GRP_NONE, r);
            chk(r, i ? 8'h01 : 8'h5A);
        end
        acc(IO, 1, PORT_EXT_INDEX, 8'h12, 1, HRED_GRP_NONE, r);
        acc(IO, 0, PORT_EXT_DATA, 0, 1, HRED_GRP_EXT_SYS, r);
        chk(r, 8'h12 ^ 8'h3C);
        chk(port_base_digit_field, 4'h3);
        acc(IO, 0, 16'h2304, 0, 1, HRED_GRP_SYS, r);
        for (int i = 1; i < 4; i++) acc(IO, 1, 16'h2310 + i, 8'hA0 + i, 1, HRED_GRP_NONE, r);
        acc(IO, 0, 16'h2310, 0, 1, HRED_GRP_NONE, r);
        chk(r, 8'h00);
        acc(HRED_KIND_MEM, 0, 32'hA3A2A120, 0, 1, HRED_GRP_MMIO, r);
        acc(HRED_KIND_MEM, 0, 32'h000A0000, 0, 1, HRED_GRP_VMEM, r);
        @(negedge clock);
        reset = 1'b1;
        strap_onboard = 1'b1;
        start();
        acc(IO, 1, PORT_ONBOARD_EN, 8'hFF, 0, HRED_GRP_NONE, r);
        chk(host_access_enabled, 1'b1);
        acc(IO, 1, PORT_EXT_INDEX, EXT_IDX_SCRATCH, 1, HRED_GRP_NONE, r);
        acc(IO, 0, PORT_EXT_DATA, 0, 1, HRED_GRP_NONE, r);
        chk(r, scratch[0][7:0]);
        bus_is_pci = 1'b1;
        acc(IO, 0, PORT_SEQ_PAIR, 0, 0, HRED_GRP_NONE, r);
        pci_cmd_enable = 2'h1;
        acc(IO, 0, PORT_SEQ_PAIR, 0, 1, HRED_GRP_SEQ, r);
        end_of_test();
    end
endmodule
